// >>> rtl/rx_fill_defines.svh
`ifndef RX_FILL_DEFINES_SVH
`define RX_FILL_DEFINES_SVH
`define CMD_FIFO_RST      8'hCA
`define CMD_SYNC_BYTE     8'hCE
`define CMD_FIFO_READ     8'hB0
`define CMD_GEN_CFG       8'h80
`define FIFO_RST_POR      16'hCA80
`define SYNC_LOW_POR      8'hD4
`define SYNC_HIGH_FIXED   8'h2D
`define GEN_CFG_POR       8'h08
`define FIFO_STORE_EN_BIT 6
`define THR_MSB           7
`define THR_LSB           4
`define SYNC_LEN_BIT      3
`define START_COND_BIT    2
`define SYNC_FILL_BIT     1
`define RST_SENS_BIT      0
`define FIFO_DEPTH        16
`define BYTE_W            8
`endif

// >>> rtl/rx_fill_pkg.sv
package rx_fill_pkg;
  typedef struct packed {
    logic [3:0] fill_threshold;
    logic       sync_length_select;
    logic       fill_start_condition;
    logic       sync_fill_run;
    logic       reset_sensitivity_select;
  } fifo_cfg_t;
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_SEARCH = 3'b010,
    ST_FILL   = 3'b100
  } fill_state_t;
  typedef enum logic [3:0] {
    CMD_IDLE  = 4'b0001,
    CMD_HIGH  = 4'b0010,
    CMD_LOW   = 4'b0100,
    CMD_DONE  = 4'b1000
  } cmd_state_t;
endpackage

// >>> rtl/byte_fifo.sv
`timescale 1ns/1ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_q[rd_q];

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else if (flush) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // byte_fifo

// >>> rtl/rx_fifo_sync_fill_control.sv
`timescale 1ns/1ps
`include "rx_fill_defines.svh"
// Functional notes
// - command code 0xCA writes low byte here
// - count stored bits, interrupt at threshold
// - threshold is four bits, max fifteen
// - byte-long sync uses only low byte
// - word-long sync is 0x2D then low byte
// - low sync byte programmable, default 0xD4
// - start bit: free fill or sync gated
// - sync-fill bit starts fill; clear stops
// - bit 0 selects reset sensitivity
// - overflowing data is discarded
// - register presets to 0xCA80
// - store only while store enable set
// - host reads data as 8-bit bytes
module rx_fifo_sync_fill_control
  import rx_fill_pkg::*;
(
  input  wire logic CORE_CLK,
  input  wire logic RESETN,
  input  wire logic SCK,
  input  wire logic CS_N,
  input  wire logic SDI,
  output logic      SDO,
  output logic      SDO_OE,
  input  wire logic RX_BIT_CLK,
  input  wire logic RX_BIT_DATA,
  output logic      FIFO_READY_IRQ,
  output logic      SENSITIVE_RESET_EN,
  output logic      OVERRUN
);
  logic [2:0] sck_sync_q;
  logic [1:0] cs_sync_q;
  logic [1:0] sdi_sync_q;
  logic [2:0] rclk_sync_q;
  logic [1:0] rdat_sync_q;
  logic       sck_rise;
  logic       sck_fall;
  logic       rclk_rise;
  logic       cs_act;

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      sck_sync_q  <= 3'h0;
      cs_sync_q   <= 2'h3;
      sdi_sync_q  <= 2'h0;
      rclk_sync_q <= 3'h0;
      rdat_sync_q <= 2'h0;
    end else begin
      sck_sync_q  <= {sck_sync_q[1:0], SCK};
      cs_sync_q   <= {cs_sync_q[0], CS_N};
      sdi_sync_q  <= {sdi_sync_q[0], SDI};
      rclk_sync_q <= {rclk_sync_q[1:0], RX_BIT_CLK};
      rdat_sync_q <= {rdat_sync_q[0], RX_BIT_DATA};
    end
  end

  assign sck_rise  = sck_sync_q[1] && !sck_sync_q[2];
  assign sck_fall  = !sck_sync_q[1] && sck_sync_q[2];
  assign rclk_rise = rclk_sync_q[1] && !rclk_sync_q[2];
  assign cs_act    = !cs_sync_q[1];

  // ---- serial command port ----
  cmd_state_t  cmd_q;
  logic [4:0]  bitcnt_q;
  logic [15:0] shift_q;
  logic [7:0]  sdo_sh_q;
  logic        word_done;
  logic        rd_cmd;
  logic        fifo_pop;

  assign word_done = sck_rise && (bitcnt_q == 5'h0F);
  // read command recognized once the top byte has arrived
  assign rd_cmd = (bitcnt_q == 5'h08)
                  && (shift_q[7:0] == `CMD_FIFO_READ);

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      cmd_q    <= CMD_IDLE;
      bitcnt_q <= 5'h00;
      shift_q  <= 16'h0000;
    end else if (!cs_act) begin
      cmd_q    <= CMD_IDLE;
      bitcnt_q <= 5'h00;
    end else begin
      case (cmd_q)
        CMD_IDLE: begin
          cmd_q <= CMD_HIGH;
        end
        CMD_HIGH, CMD_LOW: begin
          if (sck_rise) begin
            shift_q  <= {shift_q[14:0], sdi_sync_q[1]};
            bitcnt_q <= bitcnt_q + 5'h01;
            if (bitcnt_q == 5'h07) begin
              cmd_q <= CMD_LOW;
            end
            if (word_done) begin
              cmd_q <= CMD_DONE;
            end
          end
        end
        CMD_DONE: begin
          cmd_q <= CMD_DONE;
        end
        default: begin
          cmd_q <= CMD_IDLE;
        end
      endcase
    end
  end

  logic       cmd_write;
  logic [7:0] cmd_code;
  logic [7:0] cmd_low;

  assign cmd_write = cs_act && word_done;
  assign cmd_code  = shift_q[14:7];
  assign cmd_low   = {shift_q[6:0], sdi_sync_q[1]};

  // ---- configuration registers ----
  fifo_cfg_t  cfg_q;
  logic [7:0] sync_low_q;
  logic [7:0] gen_cfg_q;
  logic       run_prev_q;
  logic       rearm;

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      cfg_q <= fifo_cfg_t'(8'(`FIFO_RST_POR));
    end else if (cmd_write && cmd_code == `CMD_FIFO_RST) begin
      cfg_q <= fifo_cfg_t'(cmd_low);
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      sync_low_q <= `SYNC_LOW_POR;
    end else if (cmd_write && cmd_code == `CMD_SYNC_BYTE) begin
      sync_low_q <= cmd_low;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      gen_cfg_q <= `GEN_CFG_POR;
    end else if (cmd_write && cmd_code == `CMD_GEN_CFG) begin
      gen_cfg_q <= cmd_low;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      run_prev_q <= 1'b0;
    end else begin
      run_prev_q <= cfg_q.sync_fill_run;
    end
  end

  assign rearm = cfg_q.sync_fill_run && !run_prev_q;

  // analog detector only consumes the sensitivity level
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      SENSITIVE_RESET_EN <= 1'b1;
    end else begin
      SENSITIVE_RESET_EN <= !cfg_q.reset_sensitivity_select;
    end
  end

  // ---- sync search and fill ----
  fill_state_t fill_q;
  logic [15:0] pat_q;
  logic [15:0] pat_next;
  logic        sync_hit;
  logic [2:0]  bpos_q;
  logic [7:0]  asm_q;
  logic [3:0]  fill_cnt_q;
  logic        byte_valid;
  logic        byte_ready;
  logic [7:0]  byte_data;
  logic        stopped;

  function automatic logic sync_match(input logic [15:0] p,
                                      input logic        len_byte,
                                      input logic [7:0]  low);
    if (len_byte) begin
      sync_match = (p[7:0] == low);
    end else begin
      sync_match = (p == {`SYNC_HIGH_FIXED, low});
    end
  endfunction

  assign pat_next = {pat_q[14:0], rdat_sync_q[1]};
  assign sync_hit = rclk_rise
                    && sync_match(pat_next, cfg_q.sync_length_select,
                                  sync_low_q);
  assign stopped  = !cfg_q.sync_fill_run;

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      pat_q <= 16'h0000;
    end else if (rearm) begin
      pat_q <= 16'h0000;
    end else if (rclk_rise) begin
      pat_q <= pat_next;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      fill_q <= ST_IDLE;
    end else begin
      case (fill_q)
        ST_IDLE: begin
          if (cfg_q.sync_fill_run) begin
            fill_q <= cfg_q.fill_start_condition ? ST_FILL : ST_SEARCH;
          end
        end
        ST_SEARCH: begin
          if (stopped) begin
            fill_q <= ST_IDLE;
          end else if (cfg_q.fill_start_condition) begin
            fill_q <= ST_FILL;
          end else if (sync_hit) begin
            fill_q <= ST_FILL;
          end
        end
        ST_FILL: begin
          if (stopped) begin
            fill_q <= ST_IDLE;
          end
        end
        default: begin
          fill_q <= ST_IDLE;
        end
      endcase
    end
  end

  logic store_bit;
  assign store_bit = (fill_q == ST_FILL) && rclk_rise
                     && gen_cfg_q[`FIFO_STORE_EN_BIT];

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      bpos_q <= 3'h0;
      asm_q  <= 8'h00;
    end else if (stopped) begin
      bpos_q <= 3'h0;
    end else if (store_bit) begin
      asm_q  <= {asm_q[6:0], rdat_sync_q[1]};
      bpos_q <= bpos_q + 3'h1;
    end
  end

  assign byte_valid = store_bit && (bpos_q == 3'h7);
  assign byte_data  = {asm_q[6:0], rdat_sync_q[1]};

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      fill_cnt_q     <= 4'h0;
      FIFO_READY_IRQ <= 1'b0;
    end else if (stopped) begin
      fill_cnt_q     <= 4'h0;
      FIFO_READY_IRQ <= 1'b0;
    end else begin
      if (store_bit && fill_cnt_q != 4'hF) begin
        fill_cnt_q <= fill_cnt_q + 4'h1;
      end
      // five bits so a saturated count cannot wrap below the threshold
      if (store_bit && ({1'b0, fill_cnt_q} + 5'h01)
                       >= {1'b0, cfg_q.fill_threshold}) begin
        FIFO_READY_IRQ <= 1'b1;
      end else if (fifo_pop) begin
        FIFO_READY_IRQ <= 1'b0;
        fill_cnt_q     <= 4'h0;
      end
    end
  end

  // overrun is sticky until filling is stopped
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      OVERRUN <= 1'b0;
    end else if (byte_valid && !byte_ready) begin
      OVERRUN <= 1'b1;
    end else if (stopped) begin
      OVERRUN <= 1'b0;
    end
  end

  // ---- storage and read-out ----
  logic       out_valid;
  logic [7:0] out_data;

  byte_fifo #(
    .WIDTH (`BYTE_W),
    .DEPTH (`FIFO_DEPTH)
  ) u_fifo (
    .clk       (CORE_CLK),
    .rst_n     (RESETN),
    .flush     (rearm),
    .in_valid  (byte_valid),
    .in_ready  (byte_ready),
    .in_data   (byte_data),
    .out_valid (out_valid),
    .out_ready (fifo_pop),
    .out_data  (out_data)
  );

  assign fifo_pop = cs_act && sck_rise && rd_cmd && out_valid;

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      sdo_sh_q <= 8'h00;
      SDO      <= 1'b0;
      SDO_OE   <= 1'b0;
    end else begin
      SDO_OE <= cs_act;
      if (fifo_pop) begin
        sdo_sh_q <= out_data;
      end else if (sck_fall && bitcnt_q > 5'h08) begin
        sdo_sh_q <= {sdo_sh_q[6:0], 1'b0};
      end
      if (sck_fall) begin
        SDO <= sdo_sh_q[7];
      end
    end
  end
endmodule // rx_fifo_sync_fill_control

// >>> tb/fill_chk.sv
`timescale 1ns/1ps
module fill_chk (
  input wire logic CORE_CLK,
  input wire logic RESETN,
  input wire logic SCK,
  input wire logic CS_N,
  input wire logic SDI,
  input wire logic SDO,
  input wire logic SDO_OE,
  input wire logic RX_BIT_CLK,
  input wire logic RX_BIT_DATA,
  input wire logic FIFO_READY_IRQ,
  input wire logic SENSITIVE_RESET_EN,
  input wire logic OVERRUN
);
  logic [4:0] cs_idle_q;
  logic [5:0] bit_idle_q;
  logic       bclk_q;
  // idle counters tie output moves to recent host or link activity
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) cs_idle_q <= 5'h00;
    else if (!CS_N) cs_idle_q <= 5'h00;
    else if (cs_idle_q != 5'h1F) cs_idle_q <= cs_idle_q + 5'h01;
  end
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) bclk_q <= 1'b0;
    else bclk_q <= RX_BIT_CLK;
  end
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) bit_idle_q <= 6'h00;
    else if (bclk_q != RX_BIT_CLK) bit_idle_q <= 6'h00;
    else if (bit_idle_q != 6'h3F) bit_idle_q <= bit_idle_q + 6'h01;
  end
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);
  por_value_a: assert property ($rose(RESETN) |->
    SENSITIVE_RESET_EN && !FIFO_READY_IRQ && !OVERRUN) else $error("bad preset");
  oe_on_a: assert property ($fell(CS_N) |-> ##[1:4] SDO_OE)
    else $error("sdo enable late");
  oe_off_a: assert property ($rose(CS_N) |-> ##[1:4] !SDO_OE)
    else $error("sdo enable stuck");
  cfg_hold_a: assert property (cs_idle_q > 5'h14 |->
    $stable(SENSITIVE_RESET_EN)) else $error("config moved idle");
  irq_cause_a: assert property ($rose(FIFO_READY_IRQ) |->
    bit_idle_q < 6'h14) else $error("irq without bit");
  ovr_cause_a: assert property ($rose(OVERRUN) |->
    bit_idle_q < 6'h14) else $error("overrun without bit");
  ovr_hold_a: assert property ($fell(OVERRUN) |->
    cs_idle_q < 5'h14) else $error("overrun cleared alone");
  irq_hold_a: assert property ($fell(FIFO_READY_IRQ) |->
    cs_idle_q < 5'h14) else $error("irq cleared alone");
  cover property ($rose(FIFO_READY_IRQ));
  cover property ($rose(OVERRUN));
  cover property ($fell(SENSITIVE_RESET_EN));
endmodule // fill_chk
bind rx_fifo_sync_fill_control fill_chk u_chk (.CORE_CLK(CORE_CLK),
  .RESETN(RESETN), .SCK(SCK), .CS_N(CS_N), .SDI(SDI), .SDO(SDO),
  .SDO_OE(SDO_OE), .RX_BIT_CLK(RX_BIT_CLK), .RX_BIT_DATA(RX_BIT_DATA),
  .FIFO_READY_IRQ(FIFO_READY_IRQ),
  .SENSITIVE_RESET_EN(SENSITIVE_RESET_EN), .OVERRUN(OVERRUN));

// >>> tb/host_model.sv
`timescale 1ns/1ps
module host_model (
  output logic      sck,
  output logic      cs_n,
  output logic      sdi,
  input  wire logic sdo
);
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
  end
  // 80 ns serial period leaves the core 16 cycles per bit
  task automatic xfer(input logic [15:0] w, output logic [7:0] rd);
    rd = 8'h00;
    cs_n = 1'b0;
    #40;
    for (int i = 15; i >= 0; i--) begin
      sdi = w[i];
      #40;
      sck = 1'b1;
      // read bits leave on the fall before, so the first is at rise ten
      if (i < 7) rd = {rd[6:0], sdo};
      #40;
      sck = 1'b0;
    end
    // last read bit follows the sixteenth fall
    #40;
    rd = {rd[6:0], sdo};
    cs_n = 1'b1;
    // released line flips so a stale level never reads as data
    sdi = ~sdi;
    #100;
  endtask
endmodule // host_model

// >>> tb/tb_rx_fifo_sync_fill_control.sv
`timescale 1ns/1ps
module tb_rx_fifo_sync_fill_control;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic rx_bit_clk = 1'b0;
  logic rx_bit_data = 1'b0;
  logic sck, cs_n, sdi, sdo, sdo_oe, irq, sens, ovr;
  logic sdo_pin;
  logic [7:0] b;
  int error_cnt = 0;
  int tests_run = 0;
  always #2.5 core_clk = ~core_clk;
  // no pull on the line: a released line reads back inverted
  assign sdo_pin = sdo_oe ? sdo : !sdo;
  host_model u_host (.sck(sck), .cs_n(cs_n), .sdi(sdi), .sdo(sdo_pin));
  rx_fifo_sync_fill_control u_dut (.CORE_CLK(core_clk), .RESETN(resetn),
    .SCK(sck), .CS_N(cs_n), .SDI(sdi), .SDO(sdo), .SDO_OE(sdo_oe),
    .RX_BIT_CLK(rx_bit_clk), .RX_BIT_DATA(rx_bit_data),
    .FIFO_READY_IRQ(irq), .SENSITIVE_RESET_EN(sens), .OVERRUN(ovr));
  task check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task stop_test;
    $display("tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // link clock stands low between frames; 125 ns period
  task send(input logic [15:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      rx_bit_data = v[i];
      #65;
      rx_bit_clk = 1'b1;
      #60;
      rx_bit_clk = 1'b0;
    end
    rx_bit_data = ~rx_bit_data;
    repeat (10) @(negedge core_clk);
  endtask
  task wr(input logic [15:0] w);
    u_host.xfer(w, b);
  endtask
  task t_config;
    check({ovr, irq, sens}, 8'h01);
    wr(16'hCA81);
    check(sens, 8'h00);
    wr(16'hCB80);
    check(sens, 8'h00);
    wr(16'hCA80);
    check(sens, 8'h01);
    $display("config test done");
  endtask
  task t_free;
    wr(16'h8048);
    wr(16'hCA46);
    send(16'h0005, 3);
    check(irq, 8'h00);
    send(16'h0000, 1);
    check(irq, 8'h01);
    send(16'h0007, 4);
    u_host.xfer(16'hB000, b);
    check(b, 8'hA7);
    $display("free fill test done");
  endtask
  task t_word;
    send(16'h000F, 4);
    check(irq, 8'h01);
    wr(16'hCA80);
    check(irq, 8'h00);
    wr(16'hCA82);
    send(16'h00D4, 8);
    send(16'h2DD4, 16);
    check(irq, 8'h00);
    send(16'h003C, 8);
    check(irq, 8'h01);
    u_host.xfer(16'hB000, b);
    check(b, 8'h3C);
    $display("word sync test done");
  endtask
  task t_byte;
    wr(16'hCE5A);
    wr(16'hCA88);
    wr(16'hCA8A);
    send(16'h5A96, 16);
    check(irq, 8'h01);
    u_host.xfer(16'hB000, b);
    check(b, 8'h96);
    $display("byte sync test done");
  endtask
  task t_store_off;
    wr(16'h8008);
    wr(16'hCA80);
    wr(16'hCA46);
    send(16'hFFFF, 16);
    check(irq, 8'h00);
    $display("store off test done");
  endtask
  task t_overrun;
    wr(16'h8048);
    wr(16'hCA80);
    wr(16'hCAF6);
    send(16'h0000, 14);
    check(irq, 8'h00);
    send(16'h0000, 1);
    check(irq, 8'h01);
    repeat (7) send(16'h0000, 16);
    check(ovr, 8'h00);
    send(16'h0000, 8);
    check(ovr, 8'h00);
    send(16'h0000, 1);
    check(ovr, 8'h01);
    wr(16'hCA80);
    check({ovr, irq}, 8'h00);
    $display("overrun test done");
  endtask
  initial begin
    repeat (4) @(negedge core_clk);
    resetn = 1'b1;
    repeat (3) @(negedge core_clk);
    t_config;
    t_free;
    t_word;
    t_byte;
    t_store_off;
    t_overrun;
    stop_test;
  end
  initial begin
    #200000;
    error_cnt++;
    stop_test;
  end
endmodule // tb_rx_fifo_sync_fill_control
